// file: rtl/idt_pkg.sv
// Contract
// - normal mode: one unit, count 1..65536
// - repeat mode: reload after repeat size
// - block mode: one block, 1..65536 blocks
// - byte/word/longword units, blocks 1..256 units
// - chaining runs successive records per activation
// - chain on counter zero or always
// - addresses step inc, dec or fixed
// - short mode sign-extends 24-bit addresses
// - full mode uses 32-bit addresses
// - same vector again skips record fetch
// - read skip has its own enable
// - fixed source skips source write-back
// - fixed destination skips destination write-back
// - event link per unit or block
// - cpu interrupt under selectable condition
// - request vector selects the record
// - module stop halts new activations
// - load record, transfer, write record back
// - record pointer at base plus 4n
// - mode 00 normal, 01 repeat, 10 block
// - step 1/2/4 by size code
package idt_pkg;

  // ****************************************
  // record fields
  // ****************************************
  localparam logic [1:0] MD_NORMAL  = 2'h0;
  localparam logic [1:0] MD_REPEAT  = 2'h1;
  localparam logic [1:0] MD_BLOCK   = 2'h2;
  localparam int         MRA_MD_HI  = 7;
  localparam int         MRA_SZ_HI  = 5;
  localparam int         MRA_SM_HI  = 3;
  localparam int         MRB_CHNE   = 7;
  localparam int         MRB_CHNS   = 6;
  localparam int         MRB_DISEL  = 5;
  localparam int         MRB_DTS    = 4;
  localparam int         MRB_DM_HI  = 3;
  localparam logic [1:0] SZ_LONG    = 2'h2;
  localparam logic [1:0] WORDS_FULL  = 2'h3;
  localparam logic [1:0] WORDS_SHORT = 2'h2;
  localparam logic [31:0] REC_BYTES_FULL  = 32'h0000_0010;
  localparam logic [31:0] REC_BYTES_SHORT = 32'h0000_000c;
  localparam logic [8:0]  UNITS_MAX       = 9'h100;

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    S_IDLE, S_VEC_RD, S_REC_RD, S_DRD, S_DWR, S_WB, S_END
  } idt_state_t;

endpackage

// file: rtl/idt_fifo_if.sv
`timescale 1ns/1ps
interface idt_fifo_if #(
  parameter int WIDTH = 32
);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;

  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// file: rtl/idt_fifo.sv
`timescale 1ns/1ps
module idt_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic    i_clk_sys,
  input  wire logic    i_rst_n,
  // data path
  idt_fifo_if.fifo     f
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } idt_fifo_st_t;

  idt_fifo_st_t     r_reg;
  idt_fifo_st_t     r_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("idt_fifo depth must be a power of two");
    end
  endgenerate

  // honest flags straight from the occupancy count
  assign f.in_ready  = (r_reg.cnt != DEPTH[AW:0]);
  assign f.out_valid = (r_reg.cnt != '0);
  assign f.out_data  = mem[r_reg.rp];
  assign push        = f.in_valid && f.in_ready;
  assign pop         = f.out_valid && f.out_ready;

  // pointer and count update
  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (pop) begin
      r_next.rp = r_reg.rp + 1'b1;
    end
    r_next.cnt = r_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // storage has no reset, contents are qualified by the count
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[r_reg.wp] <= f.in_data;
    end
  end
endmodule

// file: rtl/idt_controller.sv
`timescale 1ns/1ps
module idt_controller #(
  parameter int NUM_VECTORS = 97,
  parameter int FIFO_DEPTH  = 32
) (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // transfer requests from the interrupt controller unit
  input  wire logic        i_req_valid,
  input  wire logic [6:0]  i_req_vector,
  output logic             o_req_ack,
  // control and status
  input  wire logic        i_module_stop,
  input  wire logic        i_read_skip_enable,
  input  wire logic        i_full_addr_mode,
  input  wire logic [31:0] i_vector_table_base,
  output logic             o_busy,
  // events
  output logic             o_event_link,
  output logic             o_cpu_irq,
  // system bus master
  output logic             o_mem_req,
  output logic             o_mem_we,
  output logic [1:0]       o_mem_size,
  output logic [31:0]      o_mem_addr,
  output logic [31:0]      o_mem_wdata,
  input  wire logic        i_mem_ack,
  input  wire logic [31:0] i_mem_rdata
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    idt_pkg::idt_state_t st;
    logic                mem_req;
    logic                mem_we;
    logic [1:0]          mem_size;
    logic [31:0]         mem_addr;
    logic [31:0]         mem_wdata;
    logic [1:0]          idx;
    logic [6:0]          vec;
    logic [6:0]          last_vec;
    logic                last_ok;
    logic [31:0]         rec_addr;
    logic [7:0]          mra;
    logic [7:0]          mrb;
    logic [31:0]         source_address_reg;
    logic [31:0]         destination_address_reg;
    logic [15:0]         cra;
    logic [15:0]         crb;
    logic [8:0]          rd_left;
    logic [8:0]          wr_left;
    logic                cnt_zero;
    logic                ack;
    logic                evt;
    logic                irq;
    logic                busy;
  } idt_ctl_st_t;

  idt_ctl_st_t r_reg;
  idt_ctl_st_t r_next;
  logic [1:0]  rst_sync_reg;
  logic        rst_n_int;

  idt_fifo_if #(.WIDTH(32)) fif ();

  generate
    if (NUM_VECTORS < 1 || NUM_VECTORS > 128) begin : g_chk
      $error("idt_controller vector count must fit the 7-bit vector");
    end
  endgenerate

  // ****************************************
  // helpers
  // ****************************************
  // step an address by n units; mode 0x holds, 10 adds, 11 subtracts
  function automatic logic [31:0] idt_step(input logic [31:0] a, input logic [1:0] m,
                                           input logic [1:0] sz, input logic [8:0] n);
    logic [31:0] amt;
    amt = {23'h0, n} << sz;
    if (!m[1]) begin
      idt_step = a;
    end else if (m[0]) begin
      idt_step = a - amt;
    end else begin
      idt_step = a + amt;
    end
  endfunction

  // an 8-bit size field of zero stands for 256
  function automatic logic [8:0] idt_size8(input logic [7:0] v);
    idt_size8 = (v == 8'h00) ? idt_pkg::UNITS_MAX : {1'b0, v};
  endfunction

  // short addresses cover the low and high 8 MB by sign extension
  function automatic logic [31:0] idt_sext(input logic [23:0] v);
    idt_sext = {{8{v[23]}}, v};
  endfunction

  // ****************************************
  // reset release
  // ****************************************
  // release is synchronised so no flop sees a partial release edge
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_reg[1];

  // ****************************************
  // data buffer
  // ****************************************
  idt_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n_int),
    .f         (fif.fifo)
  );

  // push on a read answer, pop on a write answer
  assign fif.in_valid  = (r_reg.st == idt_pkg::S_DRD) && r_reg.mem_req && i_mem_ack;
  assign fif.in_data   = i_mem_rdata;
  assign fif.out_ready = (r_reg.st == idt_pkg::S_DWR) && r_reg.mem_req && i_mem_ack;

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    logic [1:0]  md;
    logic [1:0]  sz;
    logic [1:0]  sm;
    logic [1:0]  dm;
    logic [1:0]  last_idx;
    logic [31:0] rec_bytes;
    logic        wb_need;
    logic [7:0]  cnt8;
    logic [15:0] cnt16;
    md        = r_reg.mra[idt_pkg::MRA_MD_HI -: 2];
    sz        = r_reg.mra[idt_pkg::MRA_SZ_HI -: 2];
    sm        = r_reg.mra[idt_pkg::MRA_SM_HI -: 2];
    dm        = r_reg.mrb[idt_pkg::MRB_DM_HI -: 2];
    last_idx  = i_full_addr_mode ? idt_pkg::WORDS_FULL : idt_pkg::WORDS_SHORT;
    rec_bytes = i_full_addr_mode ? idt_pkg::REC_BYTES_FULL : idt_pkg::REC_BYTES_SHORT;
    wb_need   = 1'b0;
    cnt8      = 8'h00;
    cnt16     = 16'h0000;
    r_next     = r_reg;
    r_next.ack = 1'b0;
    r_next.evt = 1'b0;
    r_next.irq = 1'b0;
    case (r_reg.st)
      idt_pkg::S_IDLE: begin
        if (i_req_valid && !i_module_stop) begin
          r_next.vec = i_req_vector;
          if (i_read_skip_enable && r_reg.last_ok && (r_reg.last_vec == i_req_vector)) begin
            r_next.rd_left = (md == idt_pkg::MD_BLOCK) ? idt_size8(r_reg.cra[15:8]) : 9'h001;
            r_next.wr_left = r_next.rd_left;
            r_next.st      = idt_pkg::S_DRD;
          end else begin
            r_next.mem_req  = 1'b1;
            r_next.mem_we   = 1'b0;
            r_next.mem_size = idt_pkg::SZ_LONG;
            r_next.mem_addr = i_vector_table_base + {23'h0, i_req_vector, 2'h0};
            r_next.last_ok  = 1'b1;  // lost only if this activation chains
            r_next.st       = idt_pkg::S_VEC_RD;
          end
        end
      end
      idt_pkg::S_VEC_RD: begin
        if (i_mem_ack) begin
          r_next.mem_req  = 1'b0;
          r_next.rec_addr = i_mem_rdata;
          r_next.idx      = 2'h0;
          r_next.mem_addr = i_mem_rdata;
          r_next.st       = idt_pkg::S_REC_RD;
        end
      end
      idt_pkg::S_REC_RD: begin
        // record load, one idle bus cycle between words
        if (!r_reg.mem_req) begin
          r_next.mem_req = 1'b1;
        end else if (i_mem_ack) begin
          if (i_full_addr_mode) begin
            case (r_reg.idx)
              2'h0: begin
                r_next.mra = i_mem_rdata[31:24];
                r_next.mrb = i_mem_rdata[23:16];
              end
              2'h1: r_next.source_address_reg = i_mem_rdata;
              2'h2: r_next.destination_address_reg = i_mem_rdata;
              default: {r_next.cra, r_next.crb} = i_mem_rdata;
            endcase
          end else begin
            case (r_reg.idx)
              2'h0: begin
                r_next.mra = i_mem_rdata[31:24];
                r_next.source_address_reg = idt_sext(i_mem_rdata[23:0]);
              end
              2'h1: begin
                r_next.mrb = i_mem_rdata[31:24];
                r_next.destination_address_reg = idt_sext(i_mem_rdata[23:0]);
              end
              default: {r_next.cra, r_next.crb} = i_mem_rdata;
            endcase
          end
          if (r_reg.idx == last_idx) begin
            r_next.mem_req = 1'b0;
            if (r_next.mra[idt_pkg::MRA_MD_HI -: 2] == idt_pkg::MD_BLOCK) begin
              r_next.rd_left = idt_size8(r_next.cra[15:8]);
            end else begin
              r_next.rd_left = 9'h001;
            end
            r_next.wr_left = r_next.rd_left;
            r_next.st      = idt_pkg::S_DRD;
          end else begin
            r_next.mem_req  = 1'b0;
            r_next.idx      = r_reg.idx + 2'h1;
            r_next.mem_addr = r_reg.mem_addr + 32'h0000_0004;
          end
        end
      end
      idt_pkg::S_DRD: begin
        if (!r_reg.mem_req) begin
          // reads stop on a full buffer or a zero read count and hand over to the writer
          if (r_reg.rd_left != 9'h000 && fif.in_ready) begin
            r_next.mem_req  = 1'b1;
            r_next.mem_we   = 1'b0;
            r_next.mem_size = sz;
            r_next.mem_addr = r_reg.source_address_reg;
          end else begin
            r_next.st = idt_pkg::S_DWR;
          end
        end else if (i_mem_ack) begin
          r_next.mem_req = 1'b0;
          r_next.rd_left = r_reg.rd_left - 9'h001;
          r_next.source_address_reg = idt_step(r_reg.source_address_reg, sm, sz, 9'h001);
        end
      end
      idt_pkg::S_DWR: begin
        if (!r_reg.mem_req) begin
          if (fif.out_valid) begin
            r_next.mem_req   = 1'b1;
            r_next.mem_we    = 1'b1;
            r_next.mem_size  = sz;
            r_next.mem_addr  = r_reg.destination_address_reg;
            r_next.mem_wdata = fif.out_data;
          end else if (r_reg.wr_left != 9'h000) begin
            r_next.st = idt_pkg::S_DRD;
          end else begin
            r_next.evt = 1'b1;
            r_next.idx = 2'h0;
            r_next.st  = idt_pkg::S_WB;
            // mode decode, 11 runs as normal
            case (md)
              idt_pkg::MD_REPEAT: begin
                cnt8 = r_reg.cra[7:0] - 8'h01;
                r_next.cnt_zero = 1'b0;
                if (cnt8 == 8'h00) begin
                  cnt8 = r_reg.cra[15:8];
                  if (r_reg.mrb[idt_pkg::MRB_DTS]) begin
                    r_next.source_address_reg = idt_step(r_reg.source_address_reg,
                      {sm[1], ~sm[0]}, sz, idt_size8(r_reg.cra[15:8]));
                  end else begin
                    r_next.destination_address_reg = idt_step(r_reg.destination_address_reg,
                      {dm[1], ~dm[0]}, sz, idt_size8(r_reg.cra[15:8]));
                  end
                end
                r_next.cra = {r_reg.cra[15:8], cnt8};
              end
              idt_pkg::MD_BLOCK: begin
                cnt16 = r_reg.crb - 16'h0001;
                r_next.crb      = cnt16;
                r_next.cnt_zero = (cnt16 == 16'h0000);
                if (r_reg.mrb[idt_pkg::MRB_DTS]) begin
                  r_next.source_address_reg = idt_step(r_reg.source_address_reg,
                    {sm[1], ~sm[0]}, sz, idt_size8(r_reg.cra[15:8]));
                end else begin
                  r_next.destination_address_reg = idt_step(r_reg.destination_address_reg,
                    {dm[1], ~dm[0]}, sz, idt_size8(r_reg.cra[15:8]));
                end
              end
              default: begin
                cnt16 = r_reg.cra - 16'h0001;
                r_next.cra      = cnt16;
                r_next.cnt_zero = (cnt16 == 16'h0000);
              end
            endcase
          end
        end else if (i_mem_ack) begin
          r_next.mem_req = 1'b0;
          r_next.wr_left = r_reg.wr_left - 9'h001;
          r_next.destination_address_reg = idt_step(r_reg.destination_address_reg, dm, sz,
                                                    9'h001);
        end
      end
      idt_pkg::S_WB: begin
        if (i_full_addr_mode) begin
          case (r_reg.idx)
            2'h0: wb_need = 1'b0;
            2'h1: wb_need = sm[1];
            2'h2: wb_need = dm[1];
            default: wb_need = 1'b1;
          endcase
        end else begin
          case (r_reg.idx)
            2'h0: wb_need = sm[1];
            2'h1: wb_need = dm[1];
            default: wb_need = 1'b1;
          endcase
        end
        if (!r_reg.mem_req) begin
          if (wb_need) begin
            r_next.mem_req  = 1'b1;
            r_next.mem_we   = 1'b1;
            r_next.mem_size = idt_pkg::SZ_LONG;
            r_next.mem_addr = r_reg.rec_addr + {28'h0, r_reg.idx, 2'h0};
            if (r_reg.idx == last_idx) begin
              r_next.mem_wdata = {r_reg.cra, r_reg.crb};
            end else if (i_full_addr_mode) begin
              r_next.mem_wdata = (r_reg.idx == 2'h1) ? r_reg.source_address_reg
                                                     : r_reg.destination_address_reg;
            end else if (r_reg.idx == 2'h0) begin
              r_next.mem_wdata = {r_reg.mra, r_reg.source_address_reg[23:0]};
            end else begin
              r_next.mem_wdata = {r_reg.mrb, r_reg.destination_address_reg[23:0]};
            end
          end else begin
            r_next.idx = r_reg.idx + 2'h1;
          end
        end else if (i_mem_ack) begin
          r_next.mem_req = 1'b0;
          if (r_reg.idx == last_idx) begin
            r_next.st = idt_pkg::S_END;
          end else begin
            r_next.idx = r_reg.idx + 2'h1;
          end
        end
      end
      idt_pkg::S_END: begin
        // chain: always, or only on zero count
        if (r_reg.mrb[idt_pkg::MRB_CHNE] &&
            (!r_reg.mrb[idt_pkg::MRB_CHNS] || r_reg.cnt_zero)) begin
          r_next.rec_addr = r_reg.rec_addr + rec_bytes;
          r_next.mem_addr = r_reg.rec_addr + rec_bytes;
          r_next.mem_req  = 1'b1;
          r_next.mem_we   = 1'b0;
          r_next.mem_size = idt_pkg::SZ_LONG;
          r_next.idx      = 2'h0;
          r_next.last_ok  = 1'b0;
          r_next.st       = idt_pkg::S_REC_RD;
        end else begin
          // cpu interrupt: every transfer or on zero
          r_next.irq      = r_reg.mrb[idt_pkg::MRB_DISEL] || r_reg.cnt_zero;
          r_next.ack      = 1'b1;
          r_next.last_vec = r_reg.vec;
          r_next.st       = idt_pkg::S_IDLE;
        end
      end
      default: r_next.st = idt_pkg::S_IDLE;
    endcase
    r_next.busy = (r_next.st != idt_pkg::S_IDLE);
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_req_ack    = r_reg.ack;
  assign o_busy       = r_reg.busy;
  assign o_event_link = r_reg.evt;
  assign o_cpu_irq    = r_reg.irq;
  assign o_mem_req    = r_reg.mem_req;
  assign o_mem_we     = r_reg.mem_we;
  assign o_mem_size   = r_reg.mem_size;
  assign o_mem_addr   = r_reg.mem_addr;
  assign o_mem_wdata  = r_reg.mem_wdata;
endmodule

// file: dv/idt_mem_model.sv
`timescale 1ns/1ps
module idt_mem_model (
  // clock
  input  wire logic        i_clk_sys,
  // bus from the controller
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_lat,
  output logic             o_ack,
  output logic [31:0]      o_rdata
);
  logic [31:0] mem [0:1023];
  logic [3:0]  cnt;
  logic        done;

  initial o_rdata = 32'h0;

  // one access at a time, answered after i_lat waits
  always @(posedge i_clk_sys) begin
    o_ack   <= 1'b0;
    o_rdata <= ~o_rdata;  // idle bus never shows stale data
    if (!i_req) begin
      cnt  <= 4'h0;
      done <= 1'b0;
    end else if (!done && cnt == i_lat) begin
      o_ack <= 1'b1;
      done  <= 1'b1;
      if (i_we) mem[i_addr[11:2]] <= i_wdata;
      else o_rdata <= mem[i_addr[11:2]];
    end else if (!done) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// file: dv/idt_controller_monitor.sv
`timescale 1ns/1ps
module idt_controller_monitor (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // inputs watched
  input  wire logic [6:0]  i_req_vector,
  input  wire logic        i_module_stop,
  input  wire logic        i_read_skip_enable,
  input  wire logic [31:0] i_vector_table_base,
  input  wire logic        i_mem_ack,
  // outputs watched
  input  wire logic        o_req_ack,
  input  wire logic        o_busy,
  input  wire logic        o_event_link,
  input  wire logic        o_cpu_irq,
  input  wire logic        o_mem_req,
  input  wire logic        o_mem_we,
  input  wire logic [1:0]  o_mem_size,
  input  wire logic [31:0] o_mem_addr,
  input  wire logic [31:0] o_mem_wdata
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_bus_held_wait: assert property (o_mem_req && !i_mem_ack |=> o_mem_req
    && $stable(o_mem_addr) && $stable(o_mem_we) && $stable(o_mem_wdata))
    else $error("bus request changed before ack");
  a_bus_drop_after: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
    else $error("bus request not dropped after ack");
  a_size_code_legal: assert property (o_mem_req |-> o_mem_size != 2'h3)
    else $error("illegal unit size on bus");
  a_vector_ptr_addr: assert property ($rose(o_busy) && !i_read_skip_enable
    |-> ##[0:2] (o_mem_req && !o_mem_we
    && o_mem_addr == i_vector_table_base + {23'h0, i_req_vector, 2'b00}))
    else $error("vector pointer fetched from wrong place");
  a_stop_no_start: assert property (!o_busy && i_module_stop |=> !o_busy)
    else $error("activation taken while stopped");
  a_irq_at_end: assert property (o_cpu_irq |-> o_req_ack)
    else $error("cpu interrupt away from activation end");
  a_event_one_cycle: assert property (o_event_link |=> !o_event_link)
    else $error("event link longer than one cycle");
  a_ack_one_cycle: assert property (o_req_ack |=> !o_req_ack)
    else $error("request ack longer than one cycle");
endmodule

bind idt_controller idt_controller_monitor u_mon (.i_clk_sys, .i_rst_n, .i_req_vector,
  .i_module_stop, .i_read_skip_enable, .i_vector_table_base, .i_mem_ack, .o_req_ack,
  .o_busy, .o_event_link, .o_cpu_irq, .o_mem_req, .o_mem_we, .o_mem_size, .o_mem_addr,
  .o_mem_wdata);

// file: dv/interrupt_driven_transfer_controller_test.sv
`timescale 1ns/1ps
module interrupt_driven_transfer_controller_test;
  typedef struct packed {
    logic [6:0]  v;
    logic [7:0]  ma;
    logic [7:0]  mb;
    logic [31:0] s;
    logic [31:0] d;
    logic [31:0] c;
    logic [31:0] es;
    logic [31:0] ed;
    logic [31:0] ec;
    logic [31:0] m;
    logic        ir;
  } idt_row_t;
  logic        i_clk_sys = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        req_valid = 1'b0;
  logic [6:0]  req_vector = 7'h00;
  logic        stop = 1'b0;
  logic        skip = 1'b0;
  logic [3:0]  lat = 4'h0;
  logic        full = 1'b1;
  logic        ack, busy, evl, irq, mreq, mwe, mack;
  logic [1:0]  msize;
  logic [31:0] maddr, mwdata, mrdata, rec, ptr;
  int          fails = 0;
  int          comparisons = 0;
  int          ev_cnt, irq_cnt, vec_rd, src_wb, dst_wb, n;
  idt_row_t    rows [5];

  always #50 i_clk_sys = ~i_clk_sys;

  idt_controller DUT (.i_clk_sys, .i_rst_n, .i_req_valid(req_valid),
    .i_req_vector(req_vector), .o_req_ack(ack), .i_module_stop(stop),
    .i_read_skip_enable(skip), .i_full_addr_mode(full),
    .i_vector_table_base(32'h0000_0100), .o_busy(busy), .o_event_link(evl),
    .o_cpu_irq(irq), .o_mem_req(mreq), .o_mem_we(mwe), .o_mem_size(msize),
    .o_mem_addr(maddr), .o_mem_wdata(mwdata), .i_mem_ack(mack), .i_mem_rdata(mrdata));

  idt_mem_model u_mem (.i_clk_sys, .i_req(mreq), .i_we(mwe), .i_addr(maddr),
    .i_wdata(mwdata), .i_lat(lat), .o_ack(mack), .o_rdata(mrdata));

  // snoop bus completions to see what was fetched and written back
  always @(posedge i_clk_sys) begin
    if (evl === 1'b1) ev_cnt++;
    if (irq === 1'b1) irq_cnt++;
    if (mreq && mack && !mwe && maddr == ptr) vec_rd++;
    if (mreq && mack && mwe && maddr == rec + 32'h4) src_wb++;
    if (mreq && mack && mwe && maddr == rec + 32'h8) dst_wb++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // record laid out as mode word, source, destination, counts
  task automatic put(input logic [31:0] r, input logic [7:0] ma, input logic [7:0] mb,
                     input logic [31:0] s, input logic [31:0] d, input logic [31:0] c);
    u_mem.mem[r[11:2]] = {ma, mb, 16'h0};
    u_mem.mem[r[11:2] + 10'h1] = s;
    u_mem.mem[r[11:2] + 10'h2] = d;
    u_mem.mem[r[11:2] + 10'h3] = c;
    rec = r;
  endtask

  // software activation is just another vector request
  task automatic run(input logic [6:0] v);
    u_mem.mem[10'h40 + 10'(v)] = rec;
    ptr = 32'h100 + {23'h0, v, 2'b00};
    ev_cnt = 0;
    irq_cnt = 0;
    vec_rd = 0;
    src_wb = 0;
    dst_wb = 0;
    req_vector = v;
    req_valid = 1'b1;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end while (ack !== 1'b1 && n < 3000);
    req_valid = 1'b0;
    if (n >= 3000) begin
      fails++;
      tally_and_finish();
    end
    @(posedge i_clk_sys);
    #1;
  endtask

  initial begin
    rows[0] = {7'h03, 8'h28, 8'h08, 32'h800, 32'ha00, 32'h0002_0000,
               32'h804, 32'ha04, 32'h0001_0000, 32'hffff_0000, 1'b0};
    rows[1] = {7'h60, 8'h1c, 8'h00, 32'h810, 32'ha10, 32'h0001_0000,
               32'h80e, 32'ha10, 32'h0000_0000, 32'hffff_0000, 1'b1};
    rows[2] = {7'h00, 8'h68, 8'h10, 32'h820, 32'ha20, 32'h0201_0000,
               32'h81c, 32'ha20, 32'h0202_0000, 32'hffff_0000, 1'b0};
    rows[3] = {7'h32, 8'ha8, 8'h08, 32'h900, 32'hb00, 32'h2121_0002,
               32'h984, 32'hb00, 32'h0000_0001, 32'h0000_ffff, 1'b0};
    rows[4] = {7'h07, 8'h00, 8'h28, 32'h830, 32'ha30, 32'h0005_0000,
               32'h830, 32'ha31, 32'h0004_0000, 32'hffff_0000, 1'b1};
    for (int i = 0; i < 1024; i++) u_mem.mem[i] = 32'h5a00_0000 | i;
    repeat (10) @(posedge i_clk_sys);
    #1;
    chk(busy, 0);
    chk(mreq, 0);
    repeat (10) @(posedge i_clk_sys);
    #1 i_rst_n = 1'b1;
    repeat (3) @(posedge i_clk_sys);
    #1;
    $display("reset test done");
    // ordinary cases, bus latency varied per row to stall the fifo path
    for (int i = 0; i < 5; i++) begin
      lat = 4'(i);
      put(32'h400 + 32'(i * 64), rows[i].ma, rows[i].mb, rows[i].s, rows[i].d, rows[i].c);
      run(rows[i].v);
      chk(u_mem.mem[rec[11:2] + 10'h1], rows[i].es);
      chk(u_mem.mem[rec[11:2] + 10'h2], rows[i].ed);
      chk(u_mem.mem[rec[11:2] + 10'h3] & rows[i].m, rows[i].ec & rows[i].m);
      chk(ev_cnt, 1);
      chk(irq_cnt, rows[i].ir);
      chk(src_wb, rows[i].ma[3]);
      chk(dst_wb, rows[i].mb[3]);
      chk(vec_rd, 1);
      if (rows[i].ma[5:4] == 2'h2)
        chk(u_mem.mem[rows[i].d[11:2]], 32'h5a00_0000 | rows[i].s[11:2]);
    end
    chk(u_mem.mem[10'h2e0], 32'h5a00_0260);
    $display("row tests done");
    // chain only at zero: count 2 to 1 must leave the linked record alone
    lat = 4'h1;
    put(32'h610, 8'h28, 8'h08, 32'h850, 32'ha50, 32'h0001_0000);
    put(32'h600, 8'h28, 8'hc8, 32'h840, 32'ha40, 32'h0002_0000);
    run(7'h0a);
    chk(ev_cnt, 1);
    chk(u_mem.mem[10'h186], 32'ha50);
    u_mem.mem[10'h180] = {8'h28, 8'h88, 16'h0};
    run(7'h0a);
    chk(ev_cnt, 2);
    chk(u_mem.mem[10'h186], 32'ha54);
    $display("chain test done");
    // same vector twice with skip on, then once with it off
    skip = 1'b1;
    put(32'h640, 8'h28, 8'h08, 32'h860, 32'ha60, 32'h0003_0000);
    run(7'h14);
    run(7'h14);
    chk(vec_rd, 0);
    chk(u_mem.mem[10'h192], 32'ha68);
    skip = 1'b0;
    run(7'h14);
    chk(vec_rd, 1);
    $display("skip test done");
    // request held while stopped is taken only once stop drops
    stop = 1'b1;
    req_valid = 1'b1;
    repeat (10) @(posedge i_clk_sys);
    #1;
    chk(busy, 0);
    stop = 1'b0;
    run(7'h14);
    chk(ev_cnt, 1);
    $display("stop test done");
    // short records, high-region destination
    full = 1'b0;
    rec = 32'h680;
    u_mem.mem[10'h1a0] = {8'h28, 24'h000870};
    u_mem.mem[10'h1a1] = {8'h08, 24'hffff00};
    u_mem.mem[10'h1a2] = 32'h0001_0000;
    run(7'h15);
    chk(u_mem.mem[10'h1a0], 32'h2800_0874);
    chk(u_mem.mem[10'h1a1], 32'h08ff_ff04);
    chk(u_mem.mem[10'h3c0], 32'h5a00_021c);
    $display("short test done");
    // reset mid-activation, then a clean rerun
    req_valid = 1'b1;
    repeat (4) @(posedge i_clk_sys);
    #1 i_rst_n = 1'b0;
    req_valid = 1'b0;
    #1;
    chk(busy, 0);
    chk(mreq, 0);
    repeat (2) @(posedge i_clk_sys);
    #1 i_rst_n = 1'b1;
    repeat (3) @(posedge i_clk_sys);
    #1;
    run(7'h15);
    chk(ev_cnt, 1);
    $display("mid-run reset test done");
    tally_and_finish();
  end

  // watchdog: the tests need about a thousand cycles
  initial begin
    #(100 * 20000);
    fails++;
    tally_and_finish();
  end
endmodule
